/* File: pkg/smp_defs.vh */
// constants for the static memory slow-clock and page-mode transfer engine
`ifndef SMP_DEFS_VH
`define SMP_DEFS_VH
`define SMP_SLOW_RD_ST_SETUP 10'h001
`define SMP_SLOW_RD_ST_PULSE 10'h001
`define SMP_SLOW_RD_CS_SETUP 10'h000
`define SMP_SLOW_RD_CS_PULSE 10'h002
`define SMP_SLOW_RD_CYCLE 10'h002
`define SMP_SLOW_WR_ST_SETUP 10'h001
`define SMP_SLOW_WR_ST_PULSE 10'h001
`define SMP_SLOW_WR_CS_SETUP 10'h000
`define SMP_SLOW_WR_CS_PULSE 10'h003
`define SMP_SLOW_WR_CYCLE 10'h003
`define SMP_WAIT_OFF 2'h0
`define SMP_WAIT_FROZEN 2'h2
`define SMP_WAIT_READY 2'h3
`define SMP_PAGE_4 2'h0
`define SMP_PAGE_8 2'h1
`define SMP_PAGE_16 2'h2
`define SMP_PAGE_32 2'h3
`define SMP_ST_IDLE 2'h0
`define SMP_ST_RUN 2'h1
`define SMP_ST_RELOAD 2'h2
`endif

/* File: design/smp_ctrl.v */
// static memory transfer engine: wait sampling, slow-clock waveforms, page-mode reads
`timescale 1ns/1ps
`include "smp_defs.vh"
module smp_ctrl #(
  parameter CS_CNT = 4,
  parameter CSW = 2
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_slow_req,
  input wire i_req,
  input wire i_wr,
  input wire [CSW-1:0] i_cs,
  input wire [23:0] i_addr,
  input wire i_other_access,
  input wire [5:0] i_rd_strobe_setup,
  input wire [6:0] i_rd_strobe_pulse,
  input wire [5:0] i_cs_rd_setup,
  input wire [6:0] i_cs_rd_pulse,
  input wire [8:0] i_rd_cycle_len,
  input wire [5:0] i_wr_strobe_setup,
  input wire [6:0] i_wr_strobe_pulse,
  input wire [5:0] i_cs_wr_setup,
  input wire [6:0] i_cs_wr_pulse,
  input wire [8:0] i_wr_cycle_len,
  input wire [1:0] i_ext_wait_mode,
  input wire i_page_burst_enable,
  input wire [1:0] i_page_size_sel,
  input wire i_bus16,
  input wire i_ext_wait_n,
  output reg o_ack,
  output reg o_busy,
  output reg [CS_CNT-1:0] o_chip_select_n,
  output reg o_read_strobe_n,
  output reg o_write_strobe_n,
  output reg o_slow_active,
  output reg o_reload_ws,
  output reg o_page_hit,
  output reg [4:0] o_page_offset
);

  // setup fields: 128*b5 + b4:0
  function [9:0] dec_setup;
    input [5:0] f;
    begin
      dec_setup = {2'h0, f[5], 2'h0, f[4:0]};
    end
  endfunction

  // pulse fields: 256*b6 + b5:0
  function [9:0] dec_pulse;
    input [6:0] f;
    begin
      dec_pulse = {1'b0, f[6], 2'h0, f[5:0]};
    end
  endfunction

  // cycle fields: 256*b8:7 + b6:0
  function [9:0] dec_cycle;
    input [8:0] f;
    begin
      dec_cycle = {f[8:7], 1'b0, f[6:0]};
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [9:0] cnt_r;
  reg [9:0] cnt_nxt;
  reg [9:0] st_setup_r;
  reg [9:0] st_pulse_r;
  reg [9:0] cs_setup_r;
  reg [9:0] cs_pulse_r;
  reg [9:0] cycle_r;
  reg [9:0] st_setup_nxt;
  reg [9:0] st_pulse_nxt;
  reg [9:0] cs_setup_nxt;
  reg [9:0] cs_pulse_nxt;
  reg [9:0] cycle_nxt;
  reg [1:0] wmode_r;
  reg [1:0] wmode_nxt;
  reg wr_r;
  reg wr_nxt;
  reg [CSW-1:0] cs_r;
  reg [CSW-1:0] cs_nxt;
  reg page_r;
  reg page_nxt;
  reg slow_r;
  reg park_r;
  reg park_nxt;
  reg wait_meta_r;
  reg wait_sync_r;
  reg [CSW-1:0] last_cs_r;
  reg [23:0] last_page_r;
  reg page_vld_r;
  reg page_vld_nxt;
  reg hit_nxt;
  reg ack_nxt;
  reg stall;
  reg last;
  reg st_on;
  reg cs_on;
  reg [4:0] off_mask;
  reg [23:0] page_addr;

  // page address is the address with the in-page offset bits cleared
  always @*
  begin
    case (i_page_size_sel)
      `SMP_PAGE_4: off_mask = 5'h03;
      `SMP_PAGE_8: off_mask = 5'h07;
      `SMP_PAGE_16: off_mask = 5'h0f;
      `SMP_PAGE_32: off_mask = 5'h1f;
      default: off_mask = 5'h03;
    endcase
    page_addr = {i_addr[23:5], i_addr[4:0] & ~off_mask};
  end

  // wait pin is asynchronous; only the second flop is read
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_meta_r <= 1'b1;
      wait_sync_r <= 1'b1;
    end
    else
    begin
      wait_meta_r <= i_ext_wait_n;
      wait_sync_r <= wait_meta_r;
    end
  end

  // a pulse shorter than latency + 3 lets the engine pass into hold unseen
  always @*
  begin
    stall = 1'b0;
    if (state_r == `SMP_ST_RUN && !wait_sync_r && !page_r && !slow_r)
    begin
      if (wmode_r == `SMP_WAIT_FROZEN)
        stall = st_on;
      else if (wmode_r == `SMP_WAIT_READY)
        stall = (cnt_r == st_setup_r + st_pulse_r - 10'h001);
    end
  end

  always @*
  begin
    st_on = (cnt_r >= st_setup_r) && (cnt_r < st_setup_r + st_pulse_r);
    last = (cnt_r + 10'h001 >= cycle_r) && !stall;
  end

  // transfer sequencing and parameter choice
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    st_setup_nxt = st_setup_r;
    st_pulse_nxt = st_pulse_r;
    cs_setup_nxt = cs_setup_r;
    cs_pulse_nxt = cs_pulse_r;
    cycle_nxt = cycle_r;
    wmode_nxt = wmode_r;
    wr_nxt = wr_r;
    cs_nxt = cs_r;
    page_nxt = page_r;
    park_nxt = park_r;
    page_vld_nxt = page_vld_r;
    hit_nxt = o_page_hit;
    ack_nxt = 1'b0;
    if (i_other_access)
      park_nxt = 1'b0;
    case (state_r)
      `SMP_ST_IDLE:
      begin
        if (i_slow_req != slow_r)
        begin
          state_nxt = `SMP_ST_RELOAD;
          park_nxt = 1'b0;
        end
        else if (i_req && !i_other_access)
        begin
          hit_nxt = page_vld_r && park_r && !i_wr && i_page_burst_enable
            && !slow_r && (last_cs_r == i_cs) && (last_page_r == page_addr);
          if (park_r && !hit_nxt)
            park_nxt = 1'b0;
          else
          begin
            state_nxt = `SMP_ST_RUN;
            cnt_nxt = 10'h000;
            wr_nxt = i_wr;
            cs_nxt = i_cs;
            wmode_nxt = i_ext_wait_mode;
            page_nxt = !i_wr && i_page_burst_enable && !slow_r;
            if (slow_r && !i_wr)
            begin
              st_setup_nxt = `SMP_SLOW_RD_ST_SETUP;
              st_pulse_nxt = `SMP_SLOW_RD_ST_PULSE;
              cs_setup_nxt = `SMP_SLOW_RD_CS_SETUP;
              cs_pulse_nxt = `SMP_SLOW_RD_CS_PULSE;
              cycle_nxt = `SMP_SLOW_RD_CYCLE;
            end
            else if (slow_r)
            begin
              st_setup_nxt = `SMP_SLOW_WR_ST_SETUP;
              st_pulse_nxt = `SMP_SLOW_WR_ST_PULSE;
              cs_setup_nxt = `SMP_SLOW_WR_CS_SETUP;
              cs_pulse_nxt = `SMP_SLOW_WR_CS_PULSE;
              cycle_nxt = `SMP_SLOW_WR_CYCLE;
            end
            else if (!i_wr && i_page_burst_enable)
            begin
              // setups and cycle take no part here; read select pulse times a miss
              st_setup_nxt = 10'h000;
              cs_setup_nxt = 10'h000;
              st_pulse_nxt = hit_nxt ? dec_pulse(i_rd_strobe_pulse)
                : dec_pulse(i_cs_rd_pulse);
              cs_pulse_nxt = st_pulse_nxt;
              cycle_nxt = st_pulse_nxt;
            end
            else if (!i_wr)
            begin
              st_setup_nxt = dec_setup(i_rd_strobe_setup);
              st_pulse_nxt = dec_pulse(i_rd_strobe_pulse);
              cs_setup_nxt = dec_setup(i_cs_rd_setup);
              cs_pulse_nxt = dec_pulse(i_cs_rd_pulse);
              cycle_nxt = dec_cycle(i_rd_cycle_len);
            end
            else
            begin
              st_setup_nxt = dec_setup(i_wr_strobe_setup);
              st_pulse_nxt = dec_pulse(i_wr_strobe_pulse);
              cs_setup_nxt = dec_setup(i_cs_wr_setup);
              cs_pulse_nxt = dec_pulse(i_cs_wr_pulse);
              cycle_nxt = dec_cycle(i_wr_cycle_len);
            end
          end
        end
      end
      `SMP_ST_RUN:
      begin
        // parameters were latched at start, so a mode change mid-way is harmless
        if (last)
        begin
          state_nxt = `SMP_ST_IDLE;
          ack_nxt = 1'b1;
          park_nxt = page_r && !i_other_access;
        end
        else if (!stall)
          cnt_nxt = cnt_r + 10'h001;
      end
      `SMP_ST_RELOAD:
        state_nxt = `SMP_ST_IDLE;
      default:
        state_nxt = `SMP_ST_IDLE;
    endcase
  end

  // chip select released means the stored page is no longer open
  always @*
  begin
    cs_on = 1'b0;
    if (state_nxt == `SMP_ST_RUN)
      cs_on = (cnt_nxt >= cs_setup_nxt) && (cnt_nxt < cs_setup_nxt + cs_pulse_nxt);
    else if (park_nxt)
      cs_on = 1'b1;
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= `SMP_ST_IDLE;
      cnt_r <= 10'h000;
      st_setup_r <= 10'h000;
      st_pulse_r <= 10'h000;
      cs_setup_r <= 10'h000;
      cs_pulse_r <= 10'h000;
      cycle_r <= 10'h000;
      wmode_r <= `SMP_WAIT_OFF;
      wr_r <= 1'b0;
      cs_r <= {CSW{1'b0}};
      page_r <= 1'b0;
      slow_r <= 1'b0;
      park_r <= 1'b0;
      last_cs_r <= {CSW{1'b0}};
      last_page_r <= 24'h000000;
      page_vld_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      st_setup_r <= st_setup_nxt;
      st_pulse_r <= st_pulse_nxt;
      cs_setup_r <= cs_setup_nxt;
      cs_pulse_r <= cs_pulse_nxt;
      cycle_r <= cycle_nxt;
      wmode_r <= wmode_nxt;
      wr_r <= wr_nxt;
      cs_r <= cs_nxt;
      page_r <= page_nxt;
      park_r <= park_nxt;
      if (state_r == `SMP_ST_RELOAD)
        slow_r <= i_slow_req;
      if (state_r == `SMP_ST_IDLE && state_nxt == `SMP_ST_RUN && page_nxt)
      begin
        last_cs_r <= i_cs;
        last_page_r <= page_addr;
        page_vld_r <= 1'b1;
      end
      else if (!cs_on)
        page_vld_r <= 1'b0;
    end
  end

  // registered pin and status outputs, computed from the next state
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ack <= 1'b0;
      o_busy <= 1'b0;
      o_read_strobe_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_slow_active <= 1'b0;
      o_reload_ws <= 1'b0;
      o_page_hit <= 1'b0;
      o_page_offset <= 5'h00;
    end
    else
    begin
      o_ack <= ack_nxt;
      o_busy <= (state_nxt != `SMP_ST_IDLE);
      o_slow_active <= (state_r == `SMP_ST_RELOAD) ? i_slow_req : slow_r;
      o_reload_ws <= (state_nxt == `SMP_ST_RELOAD);
      o_page_hit <= hit_nxt;
      if (state_r == `SMP_ST_IDLE && state_nxt == `SMP_ST_RUN)
        o_page_offset <= i_addr[4:0] & off_mask & {4'hf, !i_bus16};
      if (state_nxt == `SMP_ST_RUN)
      begin
        o_read_strobe_n <= !(!wr_nxt && (cnt_nxt >= st_setup_nxt)
          && (cnt_nxt < st_setup_nxt + st_pulse_nxt));
        o_write_strobe_n <= !(wr_nxt && (cnt_nxt >= st_setup_nxt)
          && (cnt_nxt < st_setup_nxt + st_pulse_nxt));
      end
      else
      begin
        o_read_strobe_n <= !park_nxt;
        o_write_strobe_n <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < CS_CNT; g = g + 1)
    begin : g_cs
      always @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
          o_chip_select_n[g] <= 1'b1;
        else
          o_chip_select_n[g] <= !(cs_on && (cs_nxt == g));
      end
    end
  endgenerate

endmodule

/* File: tb/smp_ctrl_chk.sv */
// assertion checker for the slow-clock and page-mode transfer engine
`timescale 1ns/1ps
module smp_ctrl_chk #(
  parameter CS_CNT = 4
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wr,
  input wire i_other_access,
  input wire i_page_burst_enable,
  input wire o_ack,
  input wire o_busy,
  input wire [CS_CNT-1:0] o_chip_select_n,
  input wire o_read_strobe_n,
  input wire o_write_strobe_n,
  input wire o_slow_active,
  input wire o_reload_ws,
  input wire o_page_hit
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire cs_off = &o_chip_select_n;
  property p_switch;
    $changed(o_slow_active) |-> $past(o_reload_ws);
  endproperty
  a_switch: assert property (p_switch) else $error("slow set changed without reload");
  property p_keep;
    $past(o_busy) && !$past(o_reload_ws) |-> $stable(o_slow_active);
  endproperty
  a_keep: assert property (p_keep) else $error("slow set changed in transfer");
  property p_reload_idle;
    $rose(o_reload_ws) |-> !$past(o_busy);
  endproperty
  a_reload_idle: assert property (p_reload_idle) else $error("reload inside transfer");
  property p_slow_rd;
    o_slow_active && !i_wr && $fell(cs_off) |-> o_read_strobe_n
      ##1 (!o_read_strobe_n && !cs_off) ##1 (o_read_strobe_n && cs_off && o_ack);
  endproperty
  a_slow_rd: assert property (p_slow_rd) else $error("slow read waveform");
  property p_slow_wr;
    o_slow_active && i_wr && $fell(cs_off) |-> o_write_strobe_n ##1 !o_write_strobe_n
      ##1 (o_write_strobe_n && !cs_off) ##1 (o_ack && cs_off);
  endproperty
  a_slow_wr: assert property (p_slow_wr) else $error("slow write waveform");
  property p_page;
    i_page_burst_enable && !i_wr && !o_slow_active |-> cs_off == o_read_strobe_n;
  endproperty
  a_page: assert property (p_page) else $error("page strobe and select differ");
  property p_other;
    i_other_access && !o_busy |=> cs_off;
  endproperty
  a_other: assert property (p_other) else $error("select kept after other access");
  property p_hit;
    $rose(o_busy) && o_page_hit |-> !$past(cs_off);
  endproperty
  a_hit: assert property (p_hit) else $error("hit without parked page");
  c_slow_rd: cover property (o_slow_active && o_ack && !i_wr);
  c_hit: cover property (o_page_hit && o_ack);
  c_reload: cover property (o_reload_ws);
endmodule
bind smp_ctrl smp_ctrl_chk #(.CS_CNT(CS_CNT)) u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr),
  .i_other_access(i_other_access), .i_page_burst_enable(i_page_burst_enable), .o_ack(o_ack),
  .o_busy(o_busy), .o_chip_select_n(o_chip_select_n), .o_read_strobe_n(o_read_strobe_n),
  .o_write_strobe_n(o_write_strobe_n), .o_slow_active(o_slow_active),
  .o_reload_ws(o_reload_ws), .o_page_hit(o_page_hit));

/* File: tb/smp_mem_model.sv */
// memory stand-in on chip select 0 that stretches strobes with its wait pin
`timescale 1ns/1ps
module smp_mem_model #(
  parameter LAT = 1
) (
  input wire i_clk,
  input wire i_sel_n,
  input wire i_strobe_n,
  input wire [3:0] i_stall,
  output reg o_wait_n
);
  reg [4:0] cnt_r;
  initial
  begin
    cnt_r = 5'h0;
    o_wait_n = 1'b1;
  end
  // pin falls back to its pull-up level once strobe or select ends
  always @(posedge i_clk)
  begin
    cnt_r <= (i_sel_n || i_strobe_n) ? 5'h0 : cnt_r + 5'h1;
    o_wait_n <= #1 !(!i_sel_n && !i_strobe_n && cnt_r >= LAT && cnt_r < LAT + i_stall);
  end
endmodule

/* File: tb/static_mem_slowclk_page_mode_bench.sv */
// self-checking bench for the slow-clock and page-mode transfer engine
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module static_mem_slowclk_page_mode_bench;
  reg clk = 1'b0, nrst = 1'b0, slow = 1'b0, req = 1'b0, wr = 1'b0, oth = 1'b0;
  reg pg = 1'b0, b16 = 1'b0;
  reg [1:0] cs = 2'h0, wmode = 2'h0, psel = 2'h0;
  reg [23:0] addr = 24'h0;
  reg [5:0] rss = 6'h1, css = 6'h0, wss = 6'h1, cws = 6'h0;
  reg [6:0] rsp = 7'h4, crp = 7'h2, wsp = 7'h5, cwp = 7'h7;
  reg [8:0] rcy = 9'h8, wcy = 9'h8;
  reg [3:0] stall = 4'h0;
  reg [3:0] acc;
  wire wait_n, ack, busy, rd_n, we_n, slow_act, rld, hit;
  wire [3:0] cs_n;
  wire [4:0] offs;
  int error_cnt = 0, n_tests = 0, lat;
  always #50 clk = ~clk;
  smp_ctrl uut (.i_clk(clk), .i_nrst(nrst), .i_slow_req(slow), .i_req(req), .i_wr(wr),
    .i_cs(cs), .i_addr(addr), .i_other_access(oth), .i_rd_strobe_setup(rss),
    .i_rd_strobe_pulse(rsp), .i_cs_rd_setup(css), .i_cs_rd_pulse(crp), .i_rd_cycle_len(rcy),
    .i_wr_strobe_setup(wss), .i_wr_strobe_pulse(wsp), .i_cs_wr_setup(cws),
    .i_cs_wr_pulse(cwp), .i_wr_cycle_len(wcy), .i_ext_wait_mode(wmode),
    .i_page_burst_enable(pg), .i_page_size_sel(psel), .i_bus16(b16), .i_ext_wait_n(wait_n),
    .o_ack(ack), .o_busy(busy), .o_chip_select_n(cs_n), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(we_n), .o_slow_active(slow_act), .o_reload_ws(rld), .o_page_hit(hit),
    .o_page_offset(offs));
  smp_mem_model mem (.i_clk(clk), .i_sel_n(cs_n[0]), .i_strobe_n(rd_n & we_n),
    .i_stall(stall), .o_wait_n(wait_n));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // request held until the acknowledge cycle, then dropped in it
  task automatic xfer(input bit w, input [1:0] c, input [23:0] a);
    lat = 0;
    acc = 4'hf;
    wr = w;
    cs = c;
    addr = a;
    req = 1'b1;
    do
    begin
      step();
      lat++;
      acc = acc & cs_n;
    end while (ack !== 1'b1 && lat < 200);
    req = 1'b0;
    if (ack !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic reload_wait;
    for (int i = 0; i < 20 && rld !== 1'b1; i++)
      step();
    if (rld === 1'b1)
      step();
    else
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic release_page;
    oth = 1'b1;
    step();
    oth = 1'b0;
    step();
  endtask
  task automatic t_wait;
    int exp_l[4] = '{9, 9, 15, 0};
    stall = 4'h6;
    for (int m = 0; m < 4; m++)
    begin
      wmode = m[1:0];
      xfer(1'b1, 2'h0, 24'h10);
      if (m == 3)
        `CHK(lat, 15)
      else
        `CHK(lat, exp_l[m])
      step();
    end
    wmode = 2'h0;
    stall = 4'h0;
  endtask
  task automatic t_page;
    int b;
    reg [23:0] a;
    pg = 1'b1;
    rss = 6'h5;
    css = 6'h5;
    rcy = 9'h28;
    for (int s = 0; s < 4; s++)
    begin
      psel = s[1:0];
      b16 = s[0];
      b = 4 << s;
      a = 24'h100 + 24'h40 * s;
      xfer(1'b0, 2'h0, a);
      `CHK({lat, hit}, {32'd3, 1'b0})
      step();
      xfer(1'b0, 2'h0, a + b - 1);
      `CHK({lat, hit}, {32'd5, 1'b1})
      `CHK(offs, 5'(b - 1) & ~{4'h0, b16})
      step();
      xfer(1'b0, 2'h0, a + b);
      `CHK({lat, hit}, {32'd4, 1'b0})
      step();
      release_page();
      xfer(1'b0, 2'h0, a + b);
      `CHK({lat, hit}, {32'd3, 1'b0})
      step();
      xfer(1'b0, 2'h1, a + b);
      `CHK({lat, hit}, {32'd4, 1'b0})
      step();
      release_page();
    end
    pg = 1'b0;
    rss = 6'h1;
    css = 6'h0;
    rcy = 9'h8;
    xfer(1'b0, 2'h0, 24'h100);
    step();
    xfer(1'b0, 2'h0, 24'h101);
    `CHK({lat, hit}, {32'd9, 1'b0})
    step();
  endtask
  task automatic t_slow;
    slow = 1'b1;
    reload_wait();
    `CHK({rld, slow_act}, 2'h1)
    rcy = 9'h30;
    wcy = 9'h30;
    for (int i = 0; i < 8; i++)
    begin
      xfer(i[0], i[2:1], 24'h20);
      `CHK(lat, i[0] ? 4 : 3)
      `CHK(acc, 4'hf ^ (4'h1 << i[2:1]))
      step();
    end
    fork
      xfer(1'b1, 2'h1, 24'h20);
      begin
        step();
        slow = 1'b0;
      end
    join
    `CHK(lat, 4)
    reload_wait();
    `CHK({rld, slow_act}, 2'h0)
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    `CHK({ack, busy, cs_n, rd_n, we_n, slow_act, rld, hit}, {2'h0, 4'hf, 2'h3, 3'h0})
    step();
    t_wait();
    t_page();
    t_slow();
    tally_and_finish();
  end
endmodule
